// File: logic/sram_host.v
// Behaviour
// [R1] Read when write strobe high, select low
// [R2] 15-bit address picks one byte
// [R3] Data valid after access time
// [R4] Write when strobe and select low
// [R5] Write starts at later falling edge
// [R6] Write ends at earlier rising edge
// [R7] Address steady through write cycle
// [R8] Strobe high recovery gap between cycles
// [R9] Output gate high during writes
// [R10] Device outputs off after strobe falls
// [R11] Device blocks writes below threshold
// [R12] Below threshold inputs ignored, outputs float
// [R13] Traffic only once supply above 4.5 V
// [R14] Writes blocked 40 to 120 ms after power-up
// [R15] Select after strobe keeps outputs floating
// [R16] Select or strobe high while address changes
// [R17] Select high floats bus, standby
`timescale 1ns/1ps
`default_nettype none
`include "sram_host_defines.vh"
module sram_host #(
   parameter integer LOCKOUT_CYC = `POWER_UP_LOCKOUT_CYC
) (
   input wire mclk_i,
   input wire arst_n_i,
   input wire supply_ok_i,
   input wire req_valid_i,
   input wire req_write_i,
   input wire [`ADDR_W-1:0] req_addr_i,
   input wire [`DATA_W-1:0] req_wdata_i,
   output wire req_ready_o,
   output reg rsp_valid_o,
   output reg [`DATA_W-1:0] rsp_rdata_o,
   output wire link_ready_o,
   output reg [`ADDR_W-1:0] byte_address_o,
   output reg chip_sel_n_o,
   output reg write_strobe_n_o,
   output reg output_gate_n_o,
   input wire [`DATA_W-1:0] data_bus_i,
   output reg [`DATA_W-1:0] data_bus_o,
   output reg data_bus_oe_o
);
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_RD = 3'h1;
   localparam [2:0] ST_WR = 3'h2;
   localparam [2:0] ST_REC = 3'h3;
   localparam [2:0] ST_SETUP = 3'h4;
   localparam [31:0] RD_CYC_W = `READ_LATENCY_CYC;
   localparam [31:0] WR_CYC_W = `WRITE_PULSE_CYC;
   localparam [31:0] REC_CYC_W = `STROBE_RECOVERY_CYC;
   // Eight bits suffice even for the slowest grade
   localparam [7:0] RD_CYC = RD_CYC_W[7:0];
   localparam [7:0] WR_CYC = WR_CYC_W[7:0];
   localparam [7:0] REC_CYC = REC_CYC_W[7:0];

   reg sup_s1_r, sup_s2_r;
   reg [`DATA_W-1:0] dq_s1_r, dq_s2_r;
   reg [2:0] state_r;
   reg [7:0] cnt_r;
   reg wr_r;
   wire ready;
   wire supply_lost;
   reg [2:0] state_nxt;
   reg [7:0] cnt_nxt;
   reg wr_nxt;
   reg rsp_valid_nxt;
   reg [`DATA_W-1:0] rsp_rdata_nxt;
   reg [`ADDR_W-1:0] addr_nxt;
   reg cs_n_nxt;
   reg we_n_nxt;
   reg og_n_nxt;
   reg [`DATA_W-1:0] dout_nxt;
   reg oe_nxt;

   // One end-of-count test shared by every timed phase
   function cnt_done;
      input [7:0] value;
      begin
         cnt_done = (value == 8'h00);
      end
   endfunction

   // Supply flag and data bus come from off-chip
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sup_s1_r <= 1'b0;
         sup_s2_r <= 1'b0;
         dq_s1_r <= 8'h00;
         dq_s2_r <= 8'h00;
      end else begin
         sup_s1_r <= supply_ok_i;
         sup_s2_r <= sup_s1_r;
         dq_s1_r <= data_bus_i;
         dq_s2_r <= dq_s1_r;
      end
   end

   // Host waits out the longest lockout after supply is good
   lockout_timer #(.COUNT(LOCKOUT_CYC)) u_lock (
      .mclk_i(mclk_i),
      .arst_n_i(arst_n_i),
      .supply_ok_i(sup_s2_r),
      .ready_o(ready)
   ); // see [R13] see [R14]

   // Synced flag drops a cycle before the lockout flag, so pins release without lag
   assign supply_lost = !ready || !sup_s2_r;
   assign link_ready_o = ready;
   assign req_ready_o = !supply_lost && (state_r == ST_IDLE);

   always @* begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      wr_nxt = wr_r;
      rsp_valid_nxt = 1'b0;
      rsp_rdata_nxt = rsp_rdata_o;
      addr_nxt = byte_address_o;
      cs_n_nxt = chip_sel_n_o;
      we_n_nxt = write_strobe_n_o;
      og_n_nxt = output_gate_n_o;
      dout_nxt = data_bus_o;
      oe_nxt = data_bus_oe_o;
      case (state_r)
         ST_IDLE: begin
            cs_n_nxt = 1'b1; // see [R17]
            we_n_nxt = 1'b1;
            og_n_nxt = 1'b1;
            oe_nxt = 1'b0;
            if (req_valid_i && !supply_lost) begin
               // Address changes only while select is high
               addr_nxt = req_addr_i; // see [R2] see [R16]
               wr_nxt = req_write_i;
               dout_nxt = req_wdata_i;
               state_nxt = ST_SETUP;
            end
         end
         ST_SETUP: begin
            // Address settled a cycle before select falls
            cs_n_nxt = 1'b0;
            if (wr_r) begin
               // Strobe and select fall together, outputs stay off
               we_n_nxt = 1'b0; // see [R4] see [R5] see [R15] see [R10]
               og_n_nxt = 1'b1; // see [R9]
               oe_nxt = 1'b1;
               cnt_nxt = WR_CYC;
               state_nxt = ST_WR;
            end else begin
               we_n_nxt = 1'b1; // see [R1]
               og_n_nxt = 1'b0;
               // Two extra cycles cover the input synchroniser
               cnt_nxt = RD_CYC + 8'h02; // see [R3]
               state_nxt = ST_RD;
            end
         end
         ST_RD: begin
            if (cnt_done(cnt_r)) begin
               rsp_rdata_nxt = dq_s2_r;
               rsp_valid_nxt = 1'b1;
               cs_n_nxt = 1'b1;
               og_n_nxt = 1'b1;
               cnt_nxt = REC_CYC;
               state_nxt = ST_REC;
            end else begin
               cnt_nxt = cnt_r - 8'h01;
            end
         end
         ST_WR: begin
            // Address and data held throughout the pulse
            if (cnt_done(cnt_r)) begin
               // Strobe and select rise together; data held one more cycle
               we_n_nxt = 1'b1; // see [R6] see [R7]
               cs_n_nxt = 1'b1;
               rsp_valid_nxt = 1'b1;
               cnt_nxt = REC_CYC;
               state_nxt = ST_REC;
            end else begin
               cnt_nxt = cnt_r - 8'h01;
            end
         end
         ST_REC: begin
            oe_nxt = 1'b0;
            if (cnt_done(cnt_r)) begin
               state_nxt = ST_IDLE; // see [R8]
            end else begin
               cnt_nxt = cnt_r - 8'h01;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
      // Supply lost: abandon and release pins, device ignores them anyway
      if (supply_lost) begin
         state_nxt = ST_IDLE; // see [R11] see [R12]
         cs_n_nxt = 1'b1;
         we_n_nxt = 1'b1;
         og_n_nxt = 1'b1;
         oe_nxt = 1'b0;
      end
   end

   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_r <= ST_IDLE;
         cnt_r <= 8'h00;
         wr_r <= 1'b0;
         rsp_valid_o <= 1'b0;
         rsp_rdata_o <= 8'h00;
         byte_address_o <= 15'h0000;
         chip_sel_n_o <= 1'b1;
         write_strobe_n_o <= 1'b1;
         output_gate_n_o <= 1'b1;
         data_bus_o <= 8'h00;
         data_bus_oe_o <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         wr_r <= wr_nxt;
         rsp_valid_o <= rsp_valid_nxt;
         rsp_rdata_o <= rsp_rdata_nxt;
         byte_address_o <= addr_nxt;
         chip_sel_n_o <= cs_n_nxt;
         write_strobe_n_o <= we_n_nxt;
         output_gate_n_o <= og_n_nxt;
         data_bus_o <= dout_nxt;
         data_bus_oe_o <= oe_nxt;
      end
   end
endmodule
`default_nettype wire

// File: logic/sram_host_defines.vh
`ifndef SRAM_HOST_DEFINES_VH
`define SRAM_HOST_DEFINES_VH

// Clock period in picoseconds (25 MHz)
`define CLK_PERIOD_PS 40000
// Slowest grade access time, ns
`define READ_LATENCY_LIMIT_NS 150
// Least cycles covering the access time, rounded up
`define READ_LATENCY_CYC ((`READ_LATENCY_LIMIT_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// Write pulse width, slowest grade, ns
`define WRITE_PULSE_NS 100
`define WRITE_PULSE_CYC ((`WRITE_PULSE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// Write recovery, ns
`define STROBE_RECOVERY_GAP_NS 15
`define STROBE_RECOVERY_CYC ((`STROBE_RECOVERY_GAP_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// Output turn-off after write strobe falls, ns
`define OUTPUT_TURNOFF_DELAY_NS 50
`define OUTPUT_TURNOFF_CYC ((`OUTPUT_TURNOFF_DELAY_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// Power-up lockout, ms (longest figure so the host waits it out)
`define POWER_UP_LOCKOUT_TIME_MS 120
// 25000 cycles per ms
`define POWER_UP_LOCKOUT_CYC (`POWER_UP_LOCKOUT_TIME_MS * 25000)

`define ADDR_W 15
`define DATA_W 8

`endif

// File: logic/lockout_timer.v
`timescale 1ns/1ps
`default_nettype none
module lockout_timer #(
   parameter integer COUNT = 3000000
) (
   input wire mclk_i,
   input wire arst_n_i,
   input wire supply_ok_i,
   output wire ready_o
);
   reg [31:0] cnt_r;
   reg done_r;
   always @(posedge mclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_r <= 32'h00000000;
         done_r <= 1'b0;
      end else if (!supply_ok_i) begin
         // Any dip restarts the full wait
         cnt_r <= 32'h00000000;
         done_r <= 1'b0;
      end else if (!done_r) begin
         if (cnt_r >= COUNT - 1)
            done_r <= 1'b1;
         else
            cnt_r <= cnt_r + 32'h00000001;
      end
   end
   assign ready_o = done_r;
endmodule
`default_nettype wire

// File: sim/sram_host_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module sram_host_monitor (
   input wire logic mclk_i,
   input wire logic arst_n_i,
   input wire logic req_ready_o,
   input wire logic link_ready_o,
   input wire logic [14:0] byte_address_o,
   input wire logic chip_sel_n_o,
   input wire logic write_strobe_n_o,
   input wire logic output_gate_n_o,
   input wire logic [7:0] data_bus_o,
   input wire logic data_bus_oe_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!arst_n_i);
   sequence s_rd; !output_gate_n_o [*6]; endsequence
   sequence s_desel2; chip_sel_n_o ##1 chip_sel_n_o; endsequence
   property p_oe; !output_gate_n_o |-> !data_bus_oe_o; endproperty
   a_oe: assert property (p_oe) else $error("bus clash");
   property p_rd; $fell(output_gate_n_o) |-> s_rd; endproperty
   a_rd: assert property (p_rd) else $error("short read");
   property p_rsel; !output_gate_n_o |-> !chip_sel_n_o && write_strobe_n_o; endproperty
   a_rsel: assert property (p_rsel) else $error("read mode");
   property p_wsel; !write_strobe_n_o |-> !chip_sel_n_o && output_gate_n_o; endproperty
   a_wsel: assert property (p_wsel) else $error("write mode");
   property p_wd; !write_strobe_n_o && $past(!write_strobe_n_o) |-> data_bus_oe_o && $stable(data_bus_o); endproperty
   a_wd: assert property (p_wd) else $error("write data");
   property p_adr; !chip_sel_n_o && $past(!chip_sel_n_o) |-> $stable(byte_address_o); endproperty
   a_adr: assert property (p_adr) else $error("address moved");
   property p_lock; !link_ready_o |-> chip_sel_n_o && !req_ready_o; endproperty
   a_lock: assert property (p_lock) else $error("lockout");
   property p_rec; $rose(write_strobe_n_o) |-> s_desel2; endproperty
   a_rec: assert property (p_rec) else $error("recovery");
   property p_rel; !link_ready_o |-> write_strobe_n_o && output_gate_n_o && !data_bus_oe_o; endproperty
   a_rel: assert property (p_rel) else $error("pins held in outage");
endmodule
bind sram_host sram_host_monitor i_sram_host_monitor (
   .mclk_i(mclk_i),
   .arst_n_i(arst_n_i),
   .req_ready_o(req_ready_o),
   .link_ready_o(link_ready_o),
   .byte_address_o(byte_address_o),
   .chip_sel_n_o(chip_sel_n_o),
   .write_strobe_n_o(write_strobe_n_o),
   .output_gate_n_o(output_gate_n_o),
   .data_bus_o(data_bus_o),
   .data_bus_oe_o(data_bus_oe_o)
);
`default_nettype wire

// File: sim/sram_model.sv
`timescale 1ns/1ps
`default_nettype none
module sram_model #(parameter integer DLY = 0, parameter integer LOCK_NS = 0) (
   input wire logic ok_i,
   input wire logic [14:0] adr_i,
   input wire logic cs_n_i,
   input wire logic we_n_i,
   input wire logic oe_n_i,
   input wire logic [7:0] d_i,
   output logic [7:0] q_o
);
   logic [7:0] mem [0:32767];
   logic [7:0] last = 8'h00;
   logic locked = 1'b0;
   // Writes stay blocked for a while after the supply returns
   always @(posedge ok_i) begin
      locked = 1'b1;
      #(LOCK_NS) locked = 1'b0;
   end
   wire wr = ok_i && !locked && !cs_n_i && !we_n_i;
   wire drv = ok_i && !cs_n_i && !oe_n_i && we_n_i;
   always @(negedge wr) if (ok_i) mem[adr_i] <= d_i;
   always @* if (drv) last = mem[adr_i];
   // Released bus shows inverse, never a stale match
   assign #(DLY) q_o = drv ? mem[adr_i] : ~last;
endmodule
`default_nettype wire

// File: sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam integer LOCK = 20;
   logic mclk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic supply_ok_i = 1'b1;
   logic req_valid_i = 1'b0;
   logic req_write_i = 1'b0;
   logic [14:0] req_addr_i = 15'h0000;
   logic [7:0] req_wdata_i = 8'h00;
   logic [7:0] rd;
   logic [14:0] adr [4] = '{15'h0000, 15'h2AAA, 15'h5555, 15'h7FFF};
   wire req_ready_o, rsp_valid_o, link_ready_o, chip_sel_n_o, write_strobe_n_o, output_gate_n_o, data_bus_oe_o;
   wire [7:0] rsp_rdata_o, data_bus_o, q;
   wire [14:0] byte_address_o;
   wire [7:0] data_bus_i = data_bus_oe_o ? data_bus_o : q;
   integer failures = 0;
   integer comparisons = 0;
   integer i;
   sram_host #(.LOCKOUT_CYC(LOCK)) i_sram_host (
      .mclk_i(mclk_i),
      .arst_n_i(arst_n_i),
      .supply_ok_i(supply_ok_i),
      .req_valid_i(req_valid_i),
      .req_write_i(req_write_i),
      .req_addr_i(req_addr_i),
      .req_wdata_i(req_wdata_i),
      .req_ready_o(req_ready_o),
      .rsp_valid_o(rsp_valid_o),
      .rsp_rdata_o(rsp_rdata_o),
      .link_ready_o(link_ready_o),
      .byte_address_o(byte_address_o),
      .chip_sel_n_o(chip_sel_n_o),
      .write_strobe_n_o(write_strobe_n_o),
      .output_gate_n_o(output_gate_n_o),
      .data_bus_i(data_bus_i),
      .data_bus_o(data_bus_o),
      .data_bus_oe_o(data_bus_oe_o)
   );
   sram_model #(.DLY(140), .LOCK_NS(600)) i_sram_model (.ok_i(supply_ok_i), .adr_i(byte_address_o), .cs_n_i(chip_sel_n_o),
      .we_n_i(write_strobe_n_o), .oe_n_i(output_gate_n_o), .d_i(data_bus_o), .q_o(q));
   task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task final_report;
      $display("failures %0d comparisons %0d", failures, comparisons);
      if (failures == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task xfer(input logic w, input logic [14:0] a, input logic [7:0] d);
      integer n;
      n = 0;
      req_write_i = w;
      req_addr_i = a;
      req_wdata_i = d;
      req_valid_i = 1'b1;
      while (req_ready_o !== 1'b1 && n < 50) begin
         @(negedge mclk_i);
         n++;
      end
      @(negedge mclk_i);
      req_valid_i = 1'b0;
      while (rsp_valid_o !== 1'b1 && n < 50) begin
         @(negedge mclk_i);
         n++;
      end
      rd = rsp_rdata_o;
      chk("answer", rsp_valid_o, 1'b1);
   endtask
   task t_lockout;
      repeat (LOCK) @(negedge mclk_i);
      chk("early ready", link_ready_o, 1'b0);
      repeat (4) @(negedge mclk_i);
      chk("link ready", link_ready_o, 1'b1);
   endtask
   task t_rw;
      for (i = 0; i < 4; i++) xfer(1'b1, adr[i], adr[i][7:0] ^ 8'hC3);
      for (i = 0; i < 4; i++) begin
         xfer(1'b0, adr[i], 8'h00);
         chk("read byte", rd, adr[i][7:0] ^ 8'hC3);
      end
   endtask
   task t_power;
      supply_ok_i = 1'b0;
      repeat (4) @(negedge mclk_i);
      chk("outage ready", req_ready_o, 1'b0);
      supply_ok_i = 1'b1;
      t_lockout();
      xfer(1'b0, adr[3], 8'h00);
      chk("kept byte", rd, 8'h3C);
      xfer(1'b1, adr[2], 8'h5A);
      xfer(1'b0, adr[2], 8'h00);
      chk("write after lockout", rd, 8'h5A);
   endtask
   task t_abort;
      integer n;
      n = 0;
      req_write_i = 1'b1;
      req_addr_i = adr[1];
      req_wdata_i = 8'h00;
      req_valid_i = 1'b1;
      while (write_strobe_n_o !== 1'b0 && n < 20) begin
         @(negedge mclk_i);
         n++;
      end
      req_valid_i = 1'b0;
      chk("cut start", write_strobe_n_o, 1'b0);
      supply_ok_i = 1'b0;
      // Three edges: before the pulse would end on its own
      repeat (3) @(negedge mclk_i);
      chk("cut select", chip_sel_n_o, 1'b1);
      chk("cut strobe", write_strobe_n_o, 1'b1);
      supply_ok_i = 1'b1;
      t_lockout();
      xfer(1'b0, adr[1], 8'h00);
      chk("cut write lost", rd, 8'h69);
   endtask
   initial forever #20 mclk_i = ~mclk_i;
   initial begin
      repeat (10) @(negedge mclk_i);
      arst_n_i = 1'b1;
      t_lockout();
      t_rw();
      t_power();
      t_abort();
      final_report();
   end
   initial begin
      #100000;
      failures++;
      final_report();
   end
endmodule
`default_nettype wire
